//--- src/usb_mcu_io_register_map.sv
`timescale 1ns/1ps
`include "io_map_cfg.svh"

module usb_mcu_io_register_map
	import io_map_pkg::*;
#(
	parameter logic [7:0] HIGH_PORT_BONDED = 8'hFF
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire io_req_type  io_req,
	input  wire logic [7:0]  timer_value,
	input  wire logic        rc_pin_level,
	input  wire logic        pc_step,
	input  wire logic [11:0] prog_fetch_addr,
	input  wire logic        prog_read_req,
	input  wire logic [11:0] prog_read_addr,
	input  wire logic [7:0]  prog_mem_data,
	input  wire logic        fuse_protect,
	output logic [7:0]       io_rdata,
	output logic             watchdog_clear_pulse,
	output logic [7:0]       port_low_out,
	output logic [7:0]       port_high_out,
	output logic [7:0]       port_low_irq_en_out,
	output logic [7:0]       port_high_irq_en_out,
	output logic [7:0]       port_low_pullup_out,
	output logic [7:0]       port_high_pullup_out,
	output logic [127:0]     sink_current_out,
	output logic [7:0]       usb_device_address_out,
	output logic [7:0]       global_irq_enable_out,
	output logic             rc_drive_low,
	output logic             core_clk_phase,
	output logic [11:0]      prog_counter,
	output logic [7:0]       prog_rdata
);

	io_state_type state_reg;
	io_state_type state_next;

	logic [7:0] rc_sync_a;
	logic [7:0] rc_sync_b;
	logic [7:0] timer_sync_a;
	logic [7:0] timer_sync_b;
	logic       fuse_sync_a;
	logic       fuse_sync_b;
	logic [7:0] timer_sync_c;
	logic [7:0] timer_held;

	// Pins and the free-running timer come from outside this clock domain
	always_ff @(posedge clk) begin
		if (rst) begin
			rc_sync_a    <= 8'h01;
			rc_sync_b    <= 8'h01;
			timer_sync_a <= 8'h00;
			timer_sync_b <= 8'h00;
			fuse_sync_a  <= 1'b1;
			fuse_sync_b  <= 1'b1;
			timer_sync_c <= 8'h00;
			timer_held   <= 8'h00;
		end else begin
			rc_sync_a    <= {7'h00, rc_pin_level};
			rc_sync_b    <= rc_sync_a;
			timer_sync_a <= timer_value;
			timer_sync_b <= timer_sync_a;
			fuse_sync_a  <= fuse_protect;
			fuse_sync_b  <= fuse_sync_a;
			timer_sync_c <= timer_sync_b;
			// A multi-bit count is taken only when two samples agree, so a read never sees a torn word
			if (timer_sync_b == timer_sync_c) begin
				timer_held <= timer_sync_b;
			end
		end
	end

	function automatic logic is_vector_slot(input logic [11:0] addr);
		is_vector_slot = (addr < 12'(`VECTOR_AREA_BYTES));
	endfunction : is_vector_slot

	function automatic logic is_sink(input logic [7:0] addr);
		is_sink = ((addr & `SINK_LOW_MASK) == `ADDR_LOW_SINK_BASE) ||
		          ((addr & `SINK_LOW_MASK) == `ADDR_HIGH_SINK_BASE);
	endfunction : is_sink

	function automatic logic [6:0] sink_slot(input logic [7:0] addr);
		sink_slot = {addr[3], 3'(addr & `SINK_PIN_MASK), 3'h0};
	endfunction : sink_slot

	logic io_write;
	logic io_read;

	always_comb begin
		state_next = state_reg;
		state_next.watchdog_clear = 1'b0;
		// Two phases per resonator cycle model the doubled core clock
		state_next.clk_phase = ~state_reg.clk_phase;
		// Only I/O instructions reach this space; data memory traffic never arrives here
		io_write = io_req.wr | io_req.wr_indexed;
		io_read  = io_req.rd;

		if (pc_step) begin
			state_next.prog_counter = prog_fetch_addr;
		end

		// Programmer reads are masked once the fuse is blown
		if (prog_read_req) begin
			state_next.prog_rdata = fuse_sync_b ? `PROTECTED_READ : prog_mem_data;
		end

		if (io_write) begin
			unique case (io_req.addr)
				`ADDR_PORT_LOW_DATA:    state_next.port_low_data = io_req.wdata;
				`ADDR_PORT_HIGH_DATA:   state_next.port_high_data = io_req.wdata;
				`ADDR_PORT_LOW_IRQ_EN:  state_next.port_low_irq_enable = io_req.wdata;
				`ADDR_PORT_HIGH_IRQ_EN: state_next.port_high_irq_enable = io_req.wdata & HIGH_PORT_BONDED;
				`ADDR_PORT_LOW_PULLUP:  state_next.port_low_pullup_ctrl = io_req.wdata;
				`ADDR_PORT_HIGH_PULLUP: state_next.port_high_pullup_ctrl = io_req.wdata & HIGH_PORT_BONDED;
				`ADDR_EP_A_TX_CFG:      state_next.endpoint_a_tx_config = io_req.wdata;
				`ADDR_EP_B_TX_CFG:      state_next.endpoint_b_tx_config = io_req.wdata;
				`ADDR_USB_DEV_ADDR:     state_next.usb_device_address = io_req.wdata;
				`ADDR_USB_STAT_CTRL:    state_next.usb_status_control = io_req.wdata;
				`ADDR_EP_A_RX_STAT:     state_next.endpoint_a_rx_status = io_req.wdata;
				`ADDR_GLOBAL_IRQ_EN:    state_next.global_irq_enable = io_req.wdata;
				`ADDR_WATCHDOG_CLEAR:   state_next.watchdog_clear = 1'b1;
				`ADDR_RC_TIMING:        state_next.rc_timing_control = {7'h00, io_req.wdata[0]};
				// Reserved bits are kept at zero; RUN can only be cleared, never set again
				`ADDR_PROC_STAT_CTRL: begin
					state_next.processor_status_control =
						(io_req.wdata & `PROC_STAT_WRITE_MASK & {7'h7F, state_reg.processor_status_control[0]});
				end
				default: begin
					// Unbonded high pins keep no sink register; timer and unmapped addresses ignore writes
					if (is_sink(io_req.addr) && (!io_req.addr[3] || HIGH_PORT_BONDED[io_req.addr[2:0]])) begin
						state_next.sink_current[sink_slot(io_req.addr) +: 8] = io_req.wdata;
					end
				end
			endcase
		end

		if (io_read) begin
			unique case (io_req.addr)
				`ADDR_PORT_LOW_DATA:  state_next.rdata = state_reg.port_low_data;
				`ADDR_PORT_HIGH_DATA: state_next.rdata = state_reg.port_high_data;
				`ADDR_EP_A_TX_CFG:    state_next.rdata = state_reg.endpoint_a_tx_config;
				`ADDR_EP_B_TX_CFG:    state_next.rdata = state_reg.endpoint_b_tx_config;
				`ADDR_USB_DEV_ADDR:   state_next.rdata = state_reg.usb_device_address;
				`ADDR_USB_STAT_CTRL:  state_next.rdata = state_reg.usb_status_control;
				`ADDR_EP_A_RX_STAT:   state_next.rdata = state_reg.endpoint_a_rx_status;
				`ADDR_GLOBAL_IRQ_EN:  state_next.rdata = state_reg.global_irq_enable;
				`ADDR_RC_TIMING:      state_next.rdata = rc_sync_b;
				`ADDR_FREE_TIMER:     state_next.rdata = timer_held;
				`ADDR_PROC_STAT_CTRL: state_next.rdata = state_reg.processor_status_control;
				default:              state_next.rdata = `RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg                          <= '0;
			state_reg.processor_status_control <= `RST_PROC_STAT_CTRL;
			state_reg.rc_timing_control        <= `RST_RC_TIMING;
			state_reg.prog_counter             <= `PC_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sink array: low-port pin i at bit 8i, high-port pin i at bit 64+8i
	assign io_rdata               = state_reg.rdata;
	assign watchdog_clear_pulse   = state_reg.watchdog_clear;
	assign port_low_out           = state_reg.port_low_data;
	assign port_high_out          = state_reg.port_high_data;
	assign port_low_irq_en_out    = state_reg.port_low_irq_enable;
	assign port_high_irq_en_out   = state_reg.port_high_irq_enable;
	assign port_low_pullup_out    = state_reg.port_low_pullup_ctrl;
	assign port_high_pullup_out   = state_reg.port_high_pullup_ctrl;
	assign sink_current_out       = state_reg.sink_current;
	// A single address register means exactly one device address is answered
	assign usb_device_address_out = state_reg.usb_device_address;
	assign global_irq_enable_out  = state_reg.global_irq_enable;
	assign rc_drive_low           = ~state_reg.rc_timing_control[0];
	assign core_clk_phase         = state_reg.clk_phase;
	assign prog_counter           = state_reg.prog_counter;
	assign prog_rdata             = state_reg.prog_rdata;

	a_reset_pc_zero: assert property (
		@(posedge clk) $fell(rst) |-> prog_counter == `PC_RESET)
		else $error("program counter not zero after reset");

	a_reset_status_value: assert property (
		@(posedge clk) $fell(rst) |-> state_reg.processor_status_control == `RST_PROC_STAT_CTRL)
		else $error("status register reset value wrong");

	a_reset_addr_clear: assert property (
		@(posedge clk) $fell(rst) |-> usb_device_address_out == `RST_ZERO)
		else $error("device address not cleared by reset");

	a_reset_irq_off: assert property (
		@(posedge clk) $fell(rst) |-> global_irq_enable_out == `RST_ZERO && port_low_irq_en_out == `RST_ZERO)
		else $error("interrupts enabled after reset");

	a_reset_rc_released: assert property (
		@(posedge clk) $fell(rst) |-> !rc_drive_low)
		else $error("RC pin driven low after reset");

	a_vector_bound: assert property (
		@(posedge clk) disable iff (rst) is_vector_slot(prog_counter) |-> prog_counter[11:4] == 8'h00)
		else $error("vector slot outside lowest bytes");

	a_pc_load: assert property (
		@(posedge clk) disable iff (rst) pc_step |=> prog_counter == $past(prog_fetch_addr))
		else $error("program counter not loaded");

	a_pc_hold: assert property (
		@(posedge clk) disable iff (rst) !pc_step |=> $stable(prog_counter))
		else $error("program counter moved without a step");

	a_fuse_masks: assert property (
		@(posedge clk) disable iff (rst) prog_read_req && fuse_sync_b |=> prog_rdata == `PROTECTED_READ)
		else $error("protected read leaked data");

	a_fuse_open: assert property (
		@(posedge clk) disable iff (rst) prog_read_req && !fuse_sync_b |=> prog_rdata == $past(prog_mem_data))
		else $error("unprotected read data wrong");

	a_port_low_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_PORT_LOW_DATA
		|=> port_low_out == $past(io_req.wdata))
		else $error("low port data not stored");

	a_port_high_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_PORT_HIGH_DATA
		|=> port_high_out == $past(io_req.wdata))
		else $error("high port data not stored");

	a_port_low_read: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_PORT_LOW_DATA
		|=> io_rdata == $past(port_low_out))
		else $error("low port read wrong");

	a_irq_en_readzero: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_PORT_LOW_IRQ_EN |=> io_rdata == 8'h00)
		else $error("write-only enable readable");

	a_irq_high_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_PORT_HIGH_IRQ_EN
		|=> port_high_irq_en_out == ($past(io_req.wdata) & HIGH_PORT_BONDED))
		else $error("high port enable not stored");

	a_pullup_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_PORT_LOW_PULLUP
		|=> port_low_pullup_out == $past(io_req.wdata))
		else $error("pull-up control not stored");

	a_pullup_readzero: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_PORT_HIGH_PULLUP |=> io_rdata == 8'h00)
		else $error("write-only pull-up readable");

	a_endpoint_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_EP_A_TX_CFG
		|=> state_reg.endpoint_a_tx_config == $past(io_req.wdata))
		else $error("endpoint config not stored");

	a_endpoint_read: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_EP_B_TX_CFG
		|=> io_rdata == $past(state_reg.endpoint_b_tx_config))
		else $error("endpoint config read wrong");

	a_dev_addr_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_USB_DEV_ADDR
		|=> usb_device_address_out == $past(io_req.wdata))
		else $error("device address not stored");

	a_usb_stat_read: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_USB_STAT_CTRL
		|=> io_rdata == $past(state_reg.usb_status_control))
		else $error("USB status read wrong");

	a_rx_stat_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_EP_A_RX_STAT
		|=> state_reg.endpoint_a_rx_status == $past(io_req.wdata))
		else $error("receive status not stored");

	a_irq_global_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_GLOBAL_IRQ_EN
		|=> global_irq_enable_out == $past(io_req.wdata))
		else $error("global enable not stored");

	a_rc_read_pin: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_RC_TIMING
		|=> io_rdata == {7'h00, $past(rc_sync_b[0])})
		else $error("RC read does not show the pin");

	a_rc_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_RC_TIMING
		|=> rc_drive_low == !$past(io_req.wdata[0]))
		else $error("RC drive not following control");

	a_wdog_pulse: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_WATCHDOG_CLEAR |=> watchdog_clear_pulse)
		else $error("watchdog clear pulse missing");

	a_wdog_quiet: assert property (
		@(posedge clk) disable iff (rst) !(io_write && io_req.addr == `ADDR_WATCHDOG_CLEAR) |=> !watchdog_clear_pulse)
		else $error("watchdog clear pulse without write");

	a_wdog_readzero: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_WATCHDOG_CLEAR |=> io_rdata == 8'h00)
		else $error("watchdog clear readable");

	a_timer_read: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_FREE_TIMER |=> io_rdata == $past(timer_held))
		else $error("timer read wrong");

	a_timer_no_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_FREE_TIMER
		|=> $stable({port_low_out, port_high_out, usb_device_address_out, global_irq_enable_out, sink_current_out}))
		else $error("timer write changed a register");

	a_sink_low: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_LOW_SINK_BASE
		|=> sink_current_out[7:0] == $past(io_req.wdata))
		else $error("sink register not stored");

	a_sink_low_top: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == 8'h37
		|=> sink_current_out[63:56] == $past(io_req.wdata))
		else $error("top low sink register not stored");

	a_sink_high: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_HIGH_SINK_BASE && HIGH_PORT_BONDED[0]
		|=> sink_current_out[71:64] == $past(io_req.wdata))
		else $error("high sink register not stored");

	a_sink_unbonded: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == 8'h3F && !HIGH_PORT_BONDED[7]
		|=> $stable(sink_current_out[127:120]))
		else $error("unbonded sink register populated");

	a_sink_readzero: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr[7:4] == 4'h3 |=> io_rdata == `RST_ZERO)
		else $error("write-only sink readable");

	a_unmapped_zero: assert property (
		@(posedge clk) disable iff (rst) io_req.rd && io_req.addr == 8'h40 |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");

	a_reserved_zero: assert property (
		@(posedge clk) disable iff (rst) io_req.rd && io_req.addr == 8'h02 |=> io_rdata == 8'h00)
		else $error("gap address read not zero");

	a_status_reserved: assert property (
		@(posedge clk) disable iff (rst) io_read && io_req.addr == `ADDR_PROC_STAT_CTRL
		|=> (io_rdata & ~`PROC_STAT_WRITE_MASK) == 8'h00)
		else $error("status reserved bits set");

	a_status_write: assert property (
		@(posedge clk) disable iff (rst) io_write && io_req.addr == `ADDR_PROC_STAT_CTRL
		|=> state_reg.processor_status_control[6:3] == $past(io_req.wdata[6:3]))
		else $error("status bits not stored");

	a_run_sticky: assert property (
		@(posedge clk) disable iff (rst) !state_reg.processor_status_control[0]
		|=> !state_reg.processor_status_control[0])
		else $error("run bit set again without reset");

	a_clock_double: assert property (
		@(posedge clk) disable iff (rst) core_clk_phase |=> !core_clk_phase)
		else $error("core phase not toggling");

	a_clock_rise: assert property (
		@(posedge clk) disable iff (rst) !core_clk_phase |=> core_clk_phase)
		else $error("core phase stuck low");

	a_rdata_hold: assert property (
		@(posedge clk) disable iff (rst) !io_req.rd |=> $stable(io_rdata))
		else $error("read data changed without a read");

	a_quiet_no_write: assert property (
		@(posedge clk) disable iff (rst) !io_write |=> $stable({port_low_out, usb_device_address_out}))
		else $error("register changed without a write");

endmodule : usb_mcu_io_register_map

//--- src/io_map_cfg.svh
`ifndef IO_MAP_CFG_SVH
`define IO_MAP_CFG_SVH

`define ADDR_PORT_LOW_DATA        8'h00
`define ADDR_PORT_HIGH_DATA       8'h01
`define ADDR_PORT_LOW_IRQ_EN      8'h04
`define ADDR_PORT_HIGH_IRQ_EN     8'h05
`define ADDR_PORT_LOW_PULLUP      8'h08
`define ADDR_PORT_HIGH_PULLUP     8'h09
`define ADDR_EP_A_TX_CFG          8'h10
`define ADDR_EP_B_TX_CFG          8'h11
`define ADDR_USB_DEV_ADDR         8'h12
`define ADDR_USB_STAT_CTRL        8'h13
`define ADDR_EP_A_RX_STAT         8'h14
`define ADDR_GLOBAL_IRQ_EN        8'h20
`define ADDR_WATCHDOG_CLEAR       8'h21
`define ADDR_RC_TIMING            8'h22
`define ADDR_FREE_TIMER           8'h23
`define ADDR_LOW_SINK_BASE        8'h30
`define ADDR_HIGH_SINK_BASE       8'h38
`define ADDR_PROC_STAT_CTRL       8'hFF

`define SINK_LOW_MASK             8'hF8
`define SINK_PIN_MASK             8'h07

`define RST_PROC_STAT_CTRL        8'h19
`define RST_RC_TIMING             8'h01
`define RST_ZERO                  8'h00
`define PROC_STAT_WRITE_MASK      8'h79

`define VECTOR_AREA_BYTES         16
`define VECTOR_SLOT_BYTES         2
`define VECTOR_SLOTS              (`VECTOR_AREA_BYTES / `VECTOR_SLOT_BYTES)
`define PROG_ADDR_W               12
`define PC_RESET                  12'h000
`define PROTECTED_READ            8'hFF

`endif

//--- src/io_map_pkg.sv
package io_map_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       wr_indexed;
		logic [7:0] addr;
		logic [7:0] wdata;
	} io_req_type;

	typedef struct packed {
		logic [7:0] port_low_data;
		logic [7:0] port_high_data;
		logic [7:0] port_low_irq_enable;
		logic [7:0] port_high_irq_enable;
		logic [7:0] port_low_pullup_ctrl;
		logic [7:0] port_high_pullup_ctrl;
		logic [7:0] endpoint_a_tx_config;
		logic [7:0] endpoint_b_tx_config;
		logic [7:0] usb_device_address;
		logic [7:0] usb_status_control;
		logic [7:0] endpoint_a_rx_status;
		logic [7:0] global_irq_enable;
		logic [7:0] rc_timing_control;
		logic [7:0] processor_status_control;
		logic [127:0] sink_current;
		logic [7:0] rdata;
		logic       watchdog_clear;
		logic       clk_phase;
		logic [11:0] prog_counter;
		logic [7:0] prog_rdata;
	} io_state_type;

endpackage : io_map_pkg

//--- dv/io_core_model.sv
`timescale 1ns/1ps
module io_core_model
	import io_map_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [1:0] op,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output io_req_type      io_req
);
	// An instruction holds its request for exactly one cycle; idle buses show inverted garbage
	always @(posedge clk) begin
		if (rst) begin
			io_req <= '0;
		end else if (go) begin
			io_req.rd         <= (op == 2'h0);
			io_req.wr         <= (op == 2'h1);
			io_req.wr_indexed <= (op == 2'h2);
			io_req.addr       <= addr;
			io_req.wdata      <= wdata;
		end else begin
			io_req <= {3'h0, ~io_req.addr, ~io_req.wdata};
		end
	end
endmodule : io_core_model

//--- dv/usb_mcu_io_register_map_tb.sv
`timescale 1ns/1ps
module usb_mcu_io_register_map_tb
	import io_map_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst, go, rc_pin_level, pc_step, prog_read_req, fuse_protect, wdog, rc_low, phase, p;
	logic [1:0]  op;
	logic [7:0]  addr, wdata, timer_value, prog_mem_data, io_rdata, pl, ph, pli, phi, plu, phu, uda, girq, prd;
	logic [11:0] prog_fetch_addr, prog_read_addr, pc;
	logic [127:0] sink;
	io_req_type  io_req;
	int          failures = 0;
	int          n_compared = 0;
	logic [7:0]  rw_addr [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};

	always #50 clk = ~clk;

	io_core_model core (.clk(clk), .rst(rst), .go(go), .op(op), .addr(addr), .wdata(wdata), .io_req(io_req));

	// Only the lower four high-port pins are bonded here, so unpopulated slots get exercised
	usb_mcu_io_register_map #(.HIGH_PORT_BONDED(8'h0F)) dut (.clk(clk), .rst(rst), .io_req(io_req),
		.timer_value(timer_value),
		.rc_pin_level(rc_pin_level), .pc_step(pc_step), .prog_fetch_addr(prog_fetch_addr),
		.prog_read_req(prog_read_req), .prog_read_addr(prog_read_addr), .prog_mem_data(prog_mem_data),
		.fuse_protect(fuse_protect), .io_rdata(io_rdata), .watchdog_clear_pulse(wdog), .port_low_out(pl),
		.port_high_out(ph), .port_low_irq_en_out(pli), .port_high_irq_en_out(phi), .port_low_pullup_out(plu),
		.port_high_pullup_out(phu), .sink_current_out(sink), .usb_device_address_out(uda),
		.global_irq_enable_out(girq), .rc_drive_low(rc_low), .core_clk_phase(phase), .prog_counter(pc),
		.prog_rdata(prd));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Ends one settle step after the edge where the block has answered
	task automatic issue(input logic [1:0] o, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		go <= 1'b1;
		op <= o;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
	endtask : issue

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		issue(2'h1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		issue(2'h0, a, 8'h00);
		chk(io_rdata, exp);
	endtask : rd

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1; go = 1'b0; op = 2'h0; addr = 8'h00; wdata = 8'h00; timer_value = 8'h5A;
		rc_pin_level = 1'b1; pc_step = 1'b0; prog_fetch_addr = 12'h123; prog_read_req = 1'b0;
		prog_read_addr = 12'h00F; prog_mem_data = 8'h3C; fuse_protect = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(pc, 12'h000);
		rd(8'hFF, 8'h19);
		rd(8'h22, 8'h01);
		p = phase;
		@(posedge clk);
		#1;
		chk(phase, {63'h0, ~p});
		for (int i = 0; i < 8; i++) begin wr(rw_addr[i], 8'hA0 + 8'(i)); rd(rw_addr[i], 8'hA0 + 8'(i)); end
		chk({pl, ph, uda, girq}, 32'hA0A1A4A7);
		wr(8'h04, 8'h11);
		issue(2'h2, 8'h05, 8'h22);
		wr(8'h08, 8'h33);
		wr(8'h09, 8'h44);
		chk({pli, phi, plu, phu}, 32'h11023304);
		rd(8'h04, 8'h00);
		rd(8'h09, 8'h00);
		for (int i = 0; i < 8; i++) wr(8'h30 + 8'(i), 8'h40 + 8'(i));
		chk(sink[63:0], 64'h4746454443424140);
		rd(8'h37, 8'h00);
		wr(8'h38, 8'h0F);
		chk(sink[71:64], 8'h0F);
		wr(8'h3F, 8'h55);
		chk(sink[127:120], 8'h00);
		rd(8'h3F, 8'h00);
		wr(8'h21, 8'h00);
		chk(wdog, 1'b1);
		@(posedge clk);
		#1;
		chk(wdog, 1'b0);
		rd(8'h21, 8'h00);
		wr(8'h23, 8'h00);
		rd(8'h23, 8'h5A);
		wr(8'h40, 8'h77);
		rd(8'h40, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h22, 8'h00);
		chk(rc_low, 1'b1);
		rc_pin_level <= 1'b0;
		rd(8'h22, 8'h00);
		wr(8'h22, 8'h01);
		chk(rc_low, 1'b0);
		rc_pin_level <= 1'b1;
		wr(8'hFF, 8'hFE);
		rd(8'hFF, 8'h78);
		wr(8'hFF, 8'hFF);
		rd(8'hFF, 8'h78);
		prog_read_req <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk(prd, 8'hFF);
		fuse_protect <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chk(prd, 8'h3C);
		@(posedge clk);
		pc_step <= 1'b1;
		@(posedge clk);
		pc_step <= 1'b0;
		#1;
		chk(pc, 12'h123);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk(pc, 12'h000);
		rd(8'hFF, 8'h19);
		tally_and_finish();
	end
endmodule : usb_mcu_io_register_map_tb
